// ### src/mixer_regs_audio2_dma_ctrl.sv
// Purpose: host-visible mixer registers plus audio 2 playback dma engine
// Assumes: host strobes are single-cycle and synchronous to core_clk
// Notes: dma pairs use one request and one active-high acknowledge each
`timescale 1ns/10ps
module mixer_regs_audio2_dma_ctrl #(
  parameter int fifo_depth = 32, // playback words
  parameter int word_width = 16 // bits per fifo word
) (
  input wire logic core_clk, // device clock
  input wire logic rst, // async reset, active high
  input wire logic [3:0] host_addr, // offset from audio base
  input wire logic host_wr, // write strobe, one cycle
  input wire logic host_rd, // read strobe, one cycle
  input wire logic [7:0] host_wdata, // write data
  output logic [7:0] host_rdata, // read data, valid cycle after rd
  input wire logic [3:0] dma_ack, // acknowledges of pairs a..d
  output logic [3:0] dma_req, // requests of pairs a..d
  input wire logic [7:0] dma_data, // byte from system dma
  input wire logic sample_tick, // converter sample clock pulse
  output logic [word_width-1:0] dac_sample, // sample to converter
  output logic irq_out, // audio 2 interrupt level
  output logic fifo_empty, // playback fifo empty
  output logic ch1_mix_enable, // first channel input to mixer
  output logic [1:0] rec_source, // selected record source
  output logic [2:0] fmt_mode // stereo, signed, 16-bit
);
  localparam int ptr_w = $clog2(fifo_depth);
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] play_vol, mic_vol, rec_src, main_vol, synth_vol;
    logic [7:0] cd_vol, line_vol, rate, filter, cnt_lo, cnt_hi;
    logic [7:0] xfer, fmt, ch2_vol, req_cfg, irq_ctl;
    logic [15:0] count;
    logic [ptr_w:0] wr_ptr, rd_ptr;
    logic [7:0] low_byte;
    logic half;
    logic [3:0] burst;
    logic run;
    logic [7:0] rdata;
    logic [3:0] req;
    logic [word_width-1:0] sample;
    logic ch1_en;
    logic irq;
    logic empty;
    logic [1:0] src;
  } state_s;
  state_s cur, next_st;
  logic [word_width-1:0] fifo_mem [fifo_depth];
  logic [ptr_w:0] level;
  logic f_empty, f_full, acked, push, pop, wr_data, rd_data;
  logic [3:0] burst_len;
  logic room;
  logic [2:0] mic_rd;

  // fifo occupancy and port decode
  assign level = cur.wr_ptr - cur.rd_ptr;
  assign f_empty = (level == '0);
  assign f_full = (level == (ptr_w+1)'(fifo_depth));
  assign acked = |(dma_ack & cur.req);
  // room for a whole burst, counted as if every byte took a word
  assign room = ({1'b0, level} + (ptr_w+2)'(burst_len))
                <= (ptr_w+2)'(fifo_depth);
  assign wr_data = host_wr && host_addr == mixer_regs_pkg::port_data;
  assign rd_data = host_rd && host_addr == mixer_regs_pkg::port_data;
  assign push = acked && (cur.half || !cur.fmt[mixer_regs_pkg::fmt_16bit_bit])
                && !f_full;
  assign pop = sample_tick && !f_empty
               && cur.xfer[mixer_regs_pkg::xfer_enable_bit];
  assign mic_rd = {cur.mic_vol[3], cur.mic_vol[2], 1'b1};

  // burst length from transfer type
  always_comb begin
    case (cur.xfer[7:6])
      2'b00: burst_len = 4'h1;
      2'b01: burst_len = 4'h2;
      2'b10: burst_len = 4'h4;
      default: burst_len = 4'h8;
    endcase
  end

  // fifo storage, written by dma
  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[cur.wr_ptr[ptr_w-1:0]] <= cur.fmt[0] ?
        word_width'({dma_data, cur.low_byte}) :
        word_width'({dma_data, 8'h00});
    end
  end

  // record source decode from the extended view
  function automatic logic [1:0] decode_src(input logic [2:0] s);
    if (!s[1]) decode_src = mixer_regs_pkg::src_mic;
    else if (!s[2]) decode_src = mixer_regs_pkg::src_cd_aux;
    else if (!s[0]) decode_src = mixer_regs_pkg::src_line;
    else decode_src = mixer_regs_pkg::src_mixer;
  endfunction : decode_src

  // next state of the whole bank
  always_comb begin
    next_st = cur;
    if (host_wr && host_addr == mixer_regs_pkg::port_index) begin
      next_st.index = host_wdata;
    end
    if (wr_data) begin
      case (cur.index)
        mixer_regs_pkg::idx_reset: begin
          next_st = '0;
          next_st.index = cur.index;
          next_st.wr_ptr = cur.wr_ptr;
          next_st.rd_ptr = cur.rd_ptr;
          next_st.ch1_en = cur.ch1_en;
        end
        mixer_regs_pkg::idx_play_leg:
          next_st.play_vol = host_wdata & ~mixer_regs_pkg::legacy_mask;
        mixer_regs_pkg::idx_main_leg:
          next_st.main_vol = host_wdata & ~mixer_regs_pkg::legacy_mask;
        mixer_regs_pkg::idx_synth_leg:
          next_st.synth_vol = host_wdata & ~mixer_regs_pkg::legacy_mask;
        mixer_regs_pkg::idx_cd_leg:
          next_st.cd_vol = host_wdata & ~mixer_regs_pkg::legacy_mask;
        mixer_regs_pkg::idx_line_leg:
          next_st.line_vol = host_wdata & ~mixer_regs_pkg::legacy_mask;
        mixer_regs_pkg::idx_play_ext: next_st.play_vol = host_wdata;
        mixer_regs_pkg::idx_main_ext: next_st.main_vol = host_wdata;
        mixer_regs_pkg::idx_synth_ext: next_st.synth_vol = host_wdata;
        mixer_regs_pkg::idx_cd_ext: next_st.cd_vol = host_wdata;
        mixer_regs_pkg::idx_line_ext: next_st.line_vol = host_wdata;
        mixer_regs_pkg::idx_mic_leg: begin
          case (host_wdata[2:1])
            2'b00: next_st.mic_vol = mixer_regs_pkg::mic_level_0;
            2'b01: next_st.mic_vol = mixer_regs_pkg::mic_level_1;
            2'b10: next_st.mic_vol = mixer_regs_pkg::mic_level_2;
            default: next_st.mic_vol = mixer_regs_pkg::mic_level_3;
          endcase
        end
        mixer_regs_pkg::idx_mic_ext: next_st.mic_vol = host_wdata;
        mixer_regs_pkg::idx_rec_leg:
          next_st.rec_src = {5'h00, host_wdata[2:1], 1'b0};
        mixer_regs_pkg::idx_rec_ext: next_st.rec_src = host_wdata;
        mixer_regs_pkg::idx_rate: next_st.rate = host_wdata;
        mixer_regs_pkg::idx_filter: next_st.filter = host_wdata;
        mixer_regs_pkg::idx_count_lo: next_st.cnt_lo = host_wdata;
        mixer_regs_pkg::idx_count_hi: next_st.cnt_hi = host_wdata;
        mixer_regs_pkg::idx_xfer: next_st.xfer = host_wdata;
        mixer_regs_pkg::idx_format: // done bit is hardware-owned
          next_st.fmt = {cur.fmt[7], host_wdata[6:0]};
        mixer_regs_pkg::idx_ch2_vol: next_st.ch2_vol = host_wdata;
        mixer_regs_pkg::idx_req_cfg: next_st.req_cfg = host_wdata;
        mixer_regs_pkg::idx_irq_ctl:
          next_st.irq_ctl = {cur.irq_ctl[7], host_wdata[6:0]};
        default: ;
      endcase
    end
    // starting with 1:0 both set reloads the count
    if (wr_data && cur.index == mixer_regs_pkg::idx_xfer
        && host_wdata[1:0] == 2'b11 && cur.xfer[1:0] != 2'b11) begin
      next_st.count = {cur.cnt_hi, cur.cnt_lo};
      next_st.run = 1'b1;
      next_st.fmt[mixer_regs_pkg::fmt_done_bit] = 1'b0;
    end
    if (wr_data && cur.index == mixer_regs_pkg::idx_xfer
        && host_wdata[1:0] != 2'b11) begin
      next_st.run = 1'b0;
    end
    // byte moved on an acknowledge; count up toward zero
    if (acked) begin
      // demand mode keeps the request up for the rest of the burst
      if (cur.burst > 4'h1 && cur.count != 16'hFFFF) begin
        next_st.req = cur.req;
      end else begin
        next_st.req = 4'h0;
      end
      if (cur.fmt[mixer_regs_pkg::fmt_16bit_bit]) begin
        next_st.half = ~cur.half;
        next_st.low_byte = dma_data;
      end
      next_st.burst = cur.burst - 4'h1;
      next_st.count = cur.count + 16'h0001;
      if (cur.count == 16'hFFFF) begin
        next_st.fmt[mixer_regs_pkg::fmt_done_bit] = 1'b1;
        next_st.irq_ctl[mixer_regs_pkg::irq_ch2_pend_bit] = 1'b1;
        next_st.count = {cur.cnt_hi, cur.cnt_lo};
        next_st.run = cur.xfer[mixer_regs_pkg::xfer_auto_bit];
      end
    end
    // request the chosen pair while room and enabled
    if (!acked && cur.req == 4'h0 && cur.run
        && cur.xfer[mixer_regs_pkg::xfer_dma_bit]
        && cur.xfer[mixer_regs_pkg::xfer_enable_bit]
        && cur.fmt[mixer_regs_pkg::fmt_pair_en_bit]
        && room) begin
      next_st.req = 4'h1 << cur.req_cfg[1:0];
      next_st.burst = burst_len;
    end
    // a standing request falls as soon as its enables go away
    if (!next_st.run || !next_st.xfer[mixer_regs_pkg::xfer_dma_bit]
        || !next_st.xfer[mixer_regs_pkg::xfer_enable_bit]
        || !next_st.fmt[mixer_regs_pkg::fmt_pair_en_bit]) begin
      next_st.req = 4'h0;
    end
    if (cur.burst == 4'h0 || cur.burst > burst_len) begin
      next_st.burst = burst_len;
    end
    if (push) next_st.wr_ptr = cur.wr_ptr + 1'b1;
    // empty fifo plays zeros once enabled
    if (sample_tick && cur.xfer[mixer_regs_pkg::xfer_enable_bit]) begin
      next_st.sample = f_empty ? '0 : fifo_mem[cur.rd_ptr[ptr_w-1:0]];
    end
    if (pop) next_st.rd_ptr = cur.rd_ptr + 1'b1;
    // software reset port, mixer registers untouched
    if (host_wr && host_addr == mixer_regs_pkg::port_reset
        && host_wdata[0]) begin
      next_st.ch1_en = 1'b0;
      next_st.run = 1'b0;
      next_st.req = 4'h0;
      next_st.half = 1'b0;
      if (host_wdata[mixer_regs_pkg::fifo_flush_bit]) begin
        next_st.rd_ptr = next_st.wr_ptr;
      end
    end
    // read data of each port
    next_st.rdata = cur.rdata;
    if (host_rd) begin
      case (host_addr)
        mixer_regs_pkg::port_index: next_st.rdata = cur.index;
        mixer_regs_pkg::port_fifo_status:
          next_st.rdata = {7'h00, f_empty};
        mixer_regs_pkg::port_irq_status: begin
          next_st.rdata = {cur.irq_ctl[7], 7'h00};
          next_st.irq_ctl[mixer_regs_pkg::irq_ch2_pend_bit] = 1'b0;
          if (acked && cur.count == 16'hFFFF) begin
            next_st.irq_ctl[mixer_regs_pkg::irq_ch2_pend_bit] = 1'b1;
          end
        end
        mixer_regs_pkg::port_data: begin
          case (cur.index)
            mixer_regs_pkg::idx_play_leg:
              next_st.rdata = cur.play_vol | mixer_regs_pkg::legacy_mask;
            mixer_regs_pkg::idx_main_leg:
              next_st.rdata = cur.main_vol | mixer_regs_pkg::legacy_mask;
            mixer_regs_pkg::idx_synth_leg:
              next_st.rdata = cur.synth_vol | mixer_regs_pkg::legacy_mask;
            mixer_regs_pkg::idx_cd_leg:
              next_st.rdata = cur.cd_vol | mixer_regs_pkg::legacy_mask;
            mixer_regs_pkg::idx_line_leg:
              next_st.rdata = cur.line_vol | mixer_regs_pkg::legacy_mask;
            mixer_regs_pkg::idx_play_ext: next_st.rdata = cur.play_vol;
            mixer_regs_pkg::idx_main_ext: next_st.rdata = cur.main_vol;
            mixer_regs_pkg::idx_synth_ext: next_st.rdata = cur.synth_vol;
            mixer_regs_pkg::idx_cd_ext: next_st.rdata = cur.cd_vol;
            mixer_regs_pkg::idx_line_ext: next_st.rdata = cur.line_vol;
            mixer_regs_pkg::idx_mic_leg:
              next_st.rdata = {5'h00, mic_rd};
            mixer_regs_pkg::idx_mic_ext: next_st.rdata = cur.mic_vol;
            mixer_regs_pkg::idx_rec_leg:
              next_st.rdata = {5'h00, cur.rec_src[2:1], 1'b1};
            mixer_regs_pkg::idx_rec_ext: next_st.rdata = cur.rec_src;
            mixer_regs_pkg::idx_rate: next_st.rdata = cur.rate;
            mixer_regs_pkg::idx_filter: next_st.rdata = cur.filter;
            mixer_regs_pkg::idx_count_lo: next_st.rdata = cur.cnt_lo;
            mixer_regs_pkg::idx_count_hi: next_st.rdata = cur.cnt_hi;
            mixer_regs_pkg::idx_xfer: next_st.rdata = cur.xfer;
            mixer_regs_pkg::idx_format: next_st.rdata = cur.fmt;
            mixer_regs_pkg::idx_ch2_vol: next_st.rdata = cur.ch2_vol;
            mixer_regs_pkg::idx_req_cfg: next_st.rdata = cur.req_cfg;
            mixer_regs_pkg::idx_irq_ctl: next_st.rdata = cur.irq_ctl;
            default: next_st.rdata = mixer_regs_pkg::zero_byte;
          endcase
        end
        default: next_st.rdata = mixer_regs_pkg::zero_byte;
      endcase
    end
    // registered copies of the level outputs
    next_st.irq = next_st.irq_ctl[mixer_regs_pkg::irq_ch2_pend_bit]
                  & next_st.irq_ctl[mixer_regs_pkg::irq_ch2_en_bit];
    next_st.empty = (next_st.wr_ptr == next_st.rd_ptr);
    next_st.src = decode_src(next_st.rec_src[2:0]);
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.ch1_en <= 1'b1;
      cur.empty <= 1'b1;
    end else begin
      cur <= next_st;
    end
  end

  // outputs, all from registered state
  assign host_rdata = cur.rdata;
  assign dma_req = cur.req;
  assign dac_sample = cur.sample;
  assign irq_out = cur.irq;
  assign fifo_empty = cur.empty;
  assign ch1_mix_enable = cur.ch1_en;
  assign rec_source = cur.src;
  assign fmt_mode = cur.fmt[2:0];
endmodule : mixer_regs_audio2_dma_ctrl

// ### src/mixer_regs_pkg.sv
// Purpose: constants for the mixer register bank and audio 2 dma control
// Assumes: host reaches the bank through base offsets 4 (index), 5 (data)
// Notes: volume aliases share storage between legacy and extended indices
// Overview of operation
// - request select bits 1:0 choose dma pair
// - control 2 bit 5 enables chosen pair
// - transfer bit 0 enables channel, zeros play
// - transfer bit 1 enables requests; both start
// - clear then set 1:0 restarts count
// - auto-init bit 4; clearing stops after block
// - transfer bits 7:6 give burst length
// - control 2 bits 2:0 stereo, signed, width
// - control 2 bit 7 set when count done
// - count reloads two's complement; rollover interrupts
// - reading offset E clears audio interrupt
// - offset C reports fifo empty flag
// - writing 3 to offset 6 resets, empties fifo
// - playback fifo holds 32 words
// - index at offset 4, data at offset 5
// - any write to index 00h resets mixer
// - legacy volume writes clear bits 0,4; read ones
// - extended volume aliases give full eight bits
// - legacy mic write expands bits 2:1
// - legacy mic read returns bits 3,2 and one
// - index 1Ah gives direct mic volume
// - legacy record source decode, bit 0 quirk
package mixer_regs_pkg;
  localparam logic [3:0] port_reset = 4'h6;
  localparam logic [3:0] port_index = 4'h4;
  localparam logic [3:0] port_data = 4'h5;
  localparam logic [3:0] port_fifo_status = 4'hC;
  localparam logic [3:0] port_irq_status = 4'hE;
  localparam logic [3:0] port_fifo_data = 4'hF;
  localparam logic [7:0] sw_reset_value = 8'h03;
  localparam int fifo_flush_bit = 1;
  localparam logic [7:0] idx_reset = 8'h00;
  localparam logic [7:0] idx_play_leg = 8'h04;
  localparam logic [7:0] idx_mic_leg = 8'h0A;
  localparam logic [7:0] idx_rec_leg = 8'h0C;
  localparam logic [7:0] idx_play_ext = 8'h14;
  localparam logic [7:0] idx_mic_ext = 8'h1A;
  localparam logic [7:0] idx_rec_ext = 8'h1C;
  localparam logic [7:0] idx_main_leg = 8'h22;
  localparam logic [7:0] idx_synth_leg = 8'h26;
  localparam logic [7:0] idx_cd_leg = 8'h28;
  localparam logic [7:0] idx_line_leg = 8'h2E;
  localparam logic [7:0] idx_main_ext = 8'h32;
  localparam logic [7:0] idx_synth_ext = 8'h36;
  localparam logic [7:0] idx_cd_ext = 8'h38;
  localparam logic [7:0] idx_line_ext = 8'h3E;
  localparam logic [7:0] idx_rate = 8'h70;
  localparam logic [7:0] idx_filter = 8'h72;
  localparam logic [7:0] idx_count_lo = 8'h74;
  localparam logic [7:0] idx_count_hi = 8'h75;
  localparam logic [7:0] idx_xfer = 8'h78;
  localparam logic [7:0] idx_format = 8'h7A;
  localparam logic [7:0] idx_ch2_vol = 8'h7C;
  localparam logic [7:0] idx_req_cfg = 8'h7D;
  localparam logic [7:0] idx_irq_ctl = 8'h7F;
  // legacy volume mask: bits 0 and 4
  localparam logic [7:0] legacy_mask = 8'h11;
  localparam logic [7:0] mic_level_0 = 8'h00;
  localparam logic [7:0] mic_level_1 = 8'h55;
  localparam logic [7:0] mic_level_2 = 8'hAA;
  localparam logic [7:0] mic_level_3 = 8'hFF;
  localparam logic [7:0] zero_byte = 8'h00;
  localparam int xfer_enable_bit = 0;
  localparam int xfer_dma_bit = 1;
  localparam int xfer_auto_bit = 4;
  localparam int fmt_16bit_bit = 0;
  localparam int fmt_signed_bit = 1;
  localparam int fmt_stereo_bit = 2;
  localparam int fmt_pair_en_bit = 5;
  localparam int fmt_done_bit = 7;
  localparam int irq_ch2_en_bit = 6;
  localparam int irq_ch2_pend_bit = 7;
  typedef enum logic [1:0] {
    src_mic, src_cd_aux, src_line, src_mixer
  } rec_source_e;
endpackage : mixer_regs_pkg

// ### verification/mixer_regs_checker.sv
// Purpose: port-level checks of the mixer bank and audio 2 dma engine
// Assumes: host strobes last one cycle; shadows follow host writes
// Notes: the index 00h clear also clears the shadows
`timescale 1ns/10ps
module mixer_regs_checker #(
  parameter int fifo_depth = 32, // playback words
  parameter int word_width = 16 // bits per fifo word
) (
  input wire logic core_clk, // device clock
  input wire logic rst, // async reset
  input wire logic [3:0] host_addr, // host offset
  input wire logic host_wr, // write strobe
  input wire logic host_rd, // read strobe
  input wire logic [7:0] host_wdata, // write data
  input wire logic [7:0] host_rdata, // read data
  input wire logic [3:0] dma_ack, // acknowledges
  input wire logic [3:0] dma_req, // requests
  input wire logic [7:0] dma_data, // dma byte
  input wire logic sample_tick, // sample clock
  input wire logic [word_width-1:0] dac_sample, // converter word
  input wire logic irq_out, // interrupt level
  input wire logic fifo_empty, // fifo empty
  input wire logic ch1_mix_enable, // channel 1 mix
  input wire logic [1:0] rec_source, // record source
  input wire logic [2:0] fmt_mode // format bits
);
  logic [7:0] idx;
  logic [1:0] sel, run;
  logic en5;
  wire logic dw = host_wr && host_addr == 4'h5;
  // expected source for an extended record-source write
  wire logic [1:0] rec_exp = !host_wdata[1] ? 2'd0 :
    !host_wdata[2] ? 2'd1 : {1'b1, host_wdata[0]};
  // shadows of the control fields the checks depend on
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {idx, en5, sel, run} <= '0;
    end else if (host_wr) begin
      if (host_addr == 4'h4) idx <= host_wdata;
      if (dw && idx == 8'h00) {en5, sel, run} <= '0;
      if (dw && idx == 8'h7A) en5 <= host_wdata[5];
      if (dw && idx == 8'h7D) sel <= host_wdata[1:0];
      if (dw && idx == 8'h78) run <= host_wdata[1:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [7:0] i);
    dw && idx == i;
  endsequence
  req_pair_a: assert property (
    dma_req != 4'h0 |-> dma_req == (4'h1 << sel))
    else $error("request on an unselected pair");
  pair_gate_a: assert property (
    (!en5) [*3] |-> dma_req == 4'h0)
    else $error("request while pair disabled");
  run_gate_a: assert property (
    (run != 2'b11) [*3] |-> dma_req == 4'h0)
    else $error("request while dma not started");
  fmt_track_a: assert property (
    s_wr(8'h7A) |=> fmt_mode == $past(host_wdata[2:0]))
    else $error("format bits do not follow write");
  rec_track_a: assert property (
    s_wr(8'h1C) |=> rec_source == $past(rec_exp))
    else $error("record source decode wrong");
  irq_clear_a: assert property (
    host_rd && host_addr == 4'hE |-> ##[1:2] !irq_out)
    else $error("status read left interrupt up");
  sw_reset_a: assert property (
    host_wr && host_addr == 4'h6 && host_wdata[1:0] == 2'b11
    |=> !ch1_mix_enable && fifo_empty)
    else $error("software reset effects missing");
  zero_play_a: assert property (
    sample_tick && fifo_empty && run[0] |-> ##[1:2] dac_sample == '0)
    else $error("empty fifo played nonzero sample");
endmodule : mixer_regs_checker
bind mixer_regs_audio2_dma_ctrl mixer_regs_checker #(
  .fifo_depth(fifo_depth), .word_width(word_width)) u_chk (
  .core_clk(core_clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
  .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .dma_ack(dma_ack), .dma_req(dma_req), .dma_data(dma_data),
  .sample_tick(sample_tick), .dac_sample(dac_sample), .irq_out(irq_out),
  .fifo_empty(fifo_empty), .ch1_mix_enable(ch1_mix_enable),
  .rec_source(rec_source), .fmt_mode(fmt_mode));

// ### verification/dma_host_model.sv
// Purpose: behavioural system dma controller on the request pairs
// Assumes: one acknowledge pulse moves one byte
// Notes: slow mode stretches the gap before the next acknowledge
`timescale 1ns/10ps
module dma_host_model (
  input wire logic core_clk, // device clock
  input wire logic rst, // async reset
  input wire logic slow, // long gap between bytes
  input wire logic [3:0] dma_req, // requests a..d
  output logic [3:0] dma_ack, // acknowledge pulse
  output logic [7:0] dma_data, // byte on the bus
  output logic [15:0] n_bytes // bytes handed over
);
  logic [3:0] gap;
  // answer a standing request, then keep off while it falls
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {dma_ack, dma_data, gap, n_bytes} <= '0;
    end else if (dma_ack != 4'h0 || gap != 4'h0 || dma_req == 4'h0) begin
      dma_ack <= 4'h0;
      dma_data <= ~dma_data; // no stale byte outside the ack cycle
      if (dma_ack != 4'h0) gap <= slow ? 4'h9 : 4'h3;
      else if (gap != 4'h0) gap <= gap - 4'h1;
    end else begin
      dma_ack <= dma_req;
      dma_data <= 8'hC3 ^ n_bytes[7:0];
      n_bytes <= n_bytes + 16'h0001;
    end
  end
endmodule : dma_host_model

// ### verification/test_mixer_regs_audio2_dma_ctrl.sv
// Purpose: self-checking bench for the mixer and audio 2 dma bank
// Assumes: host accesses are one-cycle strobes on core_clk
// Notes: one block per transfer type, then an auto-initialize stop
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); \
  end end
module test_mixer_regs_audio2_dma_ctrl;
  logic core_clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
  logic sample_tick = 1'b0, slow = 1'b0;
  logic [3:0] host_addr = 4'h0;
  logic [7:0] host_wdata = 8'h00;
  logic [7:0] host_rdata, dma_data, v, v0;
  logic [3:0] dma_ack, dma_req;
  logic [15:0] dac_sample, n_bytes;
  logic irq_out, fifo_empty, ch1_mix_enable;
  logic [1:0] rec_source;
  logic [2:0] fmt_mode;
  int fails = 0, n_tests = 0, cyc = 0;
  logic [7:0] leg [5] = '{8'h04, 8'h22, 8'h26, 8'h28, 8'h2E};
  logic [7:0] ext [5] = '{8'h14, 8'h32, 8'h36, 8'h38, 8'h3E};
  logic [7:0] lvl [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
  logic [7:0] rsrc [4] = '{8'h00, 8'h02, 8'h06, 8'h07};
  mixer_regs_audio2_dma_ctrl uut (
    .core_clk(core_clk), .rst(rst), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .dma_ack(dma_ack), .dma_req(dma_req),
    .dma_data(dma_data), .sample_tick(sample_tick),
    .dac_sample(dac_sample), .irq_out(irq_out), .fifo_empty(fifo_empty),
    .ch1_mix_enable(ch1_mix_enable), .rec_source(rec_source),
    .fmt_mode(fmt_mode));
  dma_host_model dma (
    .core_clk(core_clk), .rst(rst), .slow(slow), .dma_req(dma_req),
    .dma_ack(dma_ack), .dma_data(dma_data), .n_bytes(n_bytes));
  // 100 MHz clock
  always #5 core_clk = ~core_clk;
  // cut a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // one host port access; read data lands in v
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= w;
    host_rd <= !w;
    @(posedge core_clk);
    {host_wr, host_rd} <= 2'b00;
    #1 v = host_rdata;
  endtask : acc
  task automatic mw(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, 4'h4, i);
    acc(1'b1, 4'h5, d);
  endtask : mw
  task automatic mr(input logic [7:0] i);
    acc(1'b1, 4'h4, i);
    acc(1'b0, 4'h5, 8'h00);
  endtask : mr
  // main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1 `CHK("ch1_mix", 1'b1, ch1_mix_enable);
    mr(8'h32);
    v0 = v;
    for (int i = 0; i < 5; i++) begin
      mw(leg[i], 8'hA5);
      mr(ext[i]);
      `CHK("vol_ext", 8'hA4, v);
      mr(leg[i]);
      `CHK("vol_leg", 8'hB5, v);
    end
    for (int i = 0; i < 4; i++) begin
      mw(8'h0A, 8'(i << 1));
      mr(8'h1A);
      `CHK("mic_ext", lvl[i], v);
      mr(8'h0A);
      `CHK("mic_leg", {lvl[i][3:2], 1'b1}, v[2:0]);
      mw(8'h1C, rsrc[i]);
      `CHK("rec_ext", 2'(i), rec_source);
    end
    mw(8'h0C, 8'h07);
    mr(8'h0C);
    `CHK("rec_leg", 3'b111, v[2:0]);
    `CHK("rec_leg_src", 2'd2, rec_source);
    for (int i = 0; i < 8; i++) begin
      mw(8'h7A, 8'(i));
      `CHK("fmt", 3'(i), fmt_mode);
      acc(1'b0, 4'h5, 8'h00);
      `CHK("idx_hold", 3'(i), v[2:0]);
    end
    mw(8'h14, 8'h3C);
    acc(1'b1, 4'h6, 8'h03);
    `CHK("ch1_off", 1'b0, ch1_mix_enable);
    acc(1'b0, 4'hC, 8'h00);
    `CHK("fifo_empty", 1'b1, v[0]);
    mr(8'h14);
    `CHK("vol_keep", 8'h3C, v);
    mw(8'h74, 8'hFC);
    mw(8'h75, 8'hFF);
    mw(8'h7F, 8'h40);
    mw(8'h78, 8'h03);
    @(posedge core_clk) sample_tick <= 1'b1;
    @(posedge core_clk) sample_tick <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1 `CHK("dac_zero", 16'h0000, dac_sample);
    `CHK("req_gated", 4'h0, dma_req);
    // one short block per pair and transfer type, restarted each time
    for (int i = 0; i < 4; i++) begin
      slow = i[0];
      mw(8'h78, 8'h00);
      mw(8'h7D, 8'(4 + i));
      mw(8'h7A, 8'h21);
      mw(8'h78, 8'(i * 64 + 3));
      for (int k = 0; k < 300 && irq_out !== 1'b1; k++) @(posedge core_clk);
      mr(8'h7A);
      `CHK("done", 1'b1, v[7]);
      acc(1'b0, 4'hE, 8'h00);
      `CHK("pend", 1'b1, v[7]);
      #20 `CHK("irq_clr", 1'b0, irq_out);
      `CHK("bytes", 16'(4 * i + 4), n_bytes);
    end
    // auto-initialize runs on, then stops after the block in flight
    slow = 1'b1;
    mw(8'h78, 8'h00);
    mw(8'h78, 8'h13);
    for (int k = 0; k < 300 && irq_out !== 1'b1; k++) @(posedge core_clk);
    acc(1'b0, 4'hE, 8'h00);
    mw(8'h78, 8'h03);
    for (int k = 0; k < 300 && irq_out !== 1'b1; k++) @(posedge core_clk);
    acc(1'b0, 4'hE, 8'h00);
    `CHK("auto_pend", 1'b1, v[7]);
    repeat (60) @(posedge core_clk);
    `CHK("auto_stop", 16'h0018, n_bytes);
    // first queued word reaches the converter, then a flush plays zeros
    @(posedge core_clk) sample_tick <= 1'b1;
    @(posedge core_clk) sample_tick <= 1'b0;
    #1 `CHK("dac_word", 16'hC2C3, dac_sample);
    `CHK("fifo_busy", 1'b0, fifo_empty);
    acc(1'b1, 4'h6, 8'h03);
    `CHK("fifo_flush", 1'b1, fifo_empty);
    @(posedge core_clk) sample_tick <= 1'b1;
    @(posedge core_clk) sample_tick <= 1'b0;
    #1 `CHK("dac_flush", 16'h0000, dac_sample);
    // index 00h write brings the mixer back to its power-on values
    mw(8'h00, 8'h5A);
    mr(8'h32);
    `CHK("mix_init", v0, v);
    summarize();
  end
endmodule : test_mixer_regs_audio2_dma_ctrl
